// File: hw/wdtrf_cfg.svh
`ifndef WDTRF_CFG_SVH
`define WDTRF_CFG_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ---------------------------------------------------------------
`define WDTRF_CTRL_OFS   12'h060
`define WDTRF_CAUSE_OFS  12'h064

// ---------------------------------------------------------------
// Control and status fields
// ---------------------------------------------------------------
`define WDTRF_IRQF_BIT   7
`define WDTRF_IRQE_BIT   6
`define WDTRF_PSEL3_BIT  5
`define WDTRF_CE_BIT     4
`define WDTRF_WDE_BIT    3

// ---------------------------------------------------------------
// Reset-cause fields
// ---------------------------------------------------------------
`define WDTRF_SCAN_BIT   4
`define WDTRF_WATCHDOG_RESET_FLAG_BIT   3
`define WDTRF_BOR_BIT    2
`define WDTRF_PIN_BIT    1
`define WDTRF_POR_BIT    0

// ---------------------------------------------------------------
// Reset values and timing counts
// ---------------------------------------------------------------
`define WDTRF_CAUSE_RST  5'h01
`define WDTRF_CE_CYCLES  3'h4
`define WDTRF_PSEL_MAX   4'h9
`define WDTRF_BASE_LOG2  11
`define WDTRF_OSC_KHZ    128

`endif

// File: hw/wdtrf_pkg.sv
package wdtrf_pkg;

   // ---------------------------------------------------------------
   // Watchdog operating modes
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      wdtrf_stopped,
      wdtrf_irq_only,
      wdtrf_rst_only,
      wdtrf_irq_rst
   } wdtrf_mode_t;

endpackage : wdtrf_pkg

// File: hw/wdtrf_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser, one lane per bit
module wdtrf_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys_i,
   input  wire logic         rst_n_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } wdtrf_sync_t;

   wdtrf_sync_t s_r;
   wdtrf_sync_t s_nxt;

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   // First stage feeds only the second one
   always_comb begin
      s_nxt      = s_r;
      s_nxt.meta = d_i;
      s_nxt.sync = s_r.meta;
   end

   // Register with constant async reset
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q_o = s_r.sync;

endmodule : wdtrf_sync

// File: hw/wdtrf_top.sv
// What this block does
// - watchdog reset sets cause bit 3; cleared by power-on or software zero.
// - scan-chain reset sets cause bit 4; cleared by power-on or software zero.
// - brown-out reset sets cause bit 2; cleared by power-on or software zero.
// - pin reset sets cause bit 1; cleared by power-on or software zero.
// - power-on sets cause bit 0; only a software zero clears it.
// - time-out in interrupt operation sets control bit 7 flag.
// - vector execution or software writing one clears the flag.
// - interrupt requested only with global enable and bit 6 enable.
// - fuse and two enables decode into stopped, irq, reset, irq-then-reset.
// - combined mode: vector clears flag and enable, leaving reset-only mode.
// - combined mode: unserviced flag at next time-out gives system reset.
// - clearing reset-enable or changing period needs change-enable set.
// - change-enable self-clears four system cycles after being written.
// - reset-enable reads set while watchdog reset flag is set.
// - period codes 0..9 give 2048 doubling to 1048576 oscillator cycles.
// - protected change: write change and reset enables, then new values.
// - counter advances on the separate 128 kHz oscillator.
// - programmed fuse holds reset-enable at one, interrupt enable zero.
// - reset-mode time-out drives a one-cycle system reset pulse.
`timescale 1ns/1ps
`include "wdtrf_cfg.svh"

module wdtrf_top #(
   parameter int BASE_LOG2 = `WDTRF_BASE_LOG2,
   parameter int ADDR_W    = 12
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Core side
   input  wire logic              global_irq_en_i,
   input  wire logic              irq_ack_i,
   input  wire logic              wdr_i,
   output logic                   irq_o,
   output logic                   sys_reset_o,
   // Outside the clock domain
   input  wire logic              wdt_osc_i,
   input  wire logic              always_on_fuse_i,
   input  wire logic              pin_reset_i,
   input  wire logic              brownout_reset_i,
   input  wire logic              scan_reset_i
);

   localparam int CNT_W = BASE_LOG2 + int'(`WDTRF_PSEL_MAX);

   typedef struct packed {
      logic             osc_prev;
      logic [CNT_W-1:0] cnt;
      logic             irq_flag;
      logic             irq_en;
      logic [3:0]       psel;
      logic             ce;
      logic [2:0]       ce_cnt;
      logic             reset_enable;
      logic [4:0]       cause;
      logic             rst_pulse;
      logic [31:0]      rdata;
   } wdtrf_state_t;

   wdtrf_state_t s_r;
   wdtrf_state_t s_nxt;

   // ---------------------------------------------------------------
   // Reset release and input synchronisers
   // ---------------------------------------------------------------
   logic       rst_sync_n;
   logic [4:0] pins_s;
   logic       osc_s;
   logic       fuse_s;
   logic       pin_s;
   logic       bor_s;
   logic       scan_s;

   // Async assert, synchronous release
   wdtrf_sync #(
      .W (1)
   ) u_rst_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .d_i       (1'b1),
      .q_o       (rst_sync_n)
   );

   // Oscillator and reset sources come from other domains
   wdtrf_sync #(
      .W (5)
   ) u_pin_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_sync_n),
      .d_i       ({scan_reset_i, brownout_reset_i, pin_reset_i,
                   always_on_fuse_i, wdt_osc_i}),
      .q_o       (pins_s)
   );

   assign osc_s  = pins_s[0];
   assign fuse_s = pins_s[1];
   assign pin_s  = pins_s[2];
   assign bor_s  = pins_s[3];
   assign scan_s = pins_s[4];

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   logic                  wde_eff;
   logic                  irqe_eff;
   wdtrf_pkg::wdtrf_mode_t mode;

   // Fuse and reset flag both force reset-enable on
   // Keeps a failing system resetting until software clears the flag
   assign wde_eff  = s_r.reset_enable | s_r.cause[`WDTRF_WATCHDOG_RESET_FLAG_BIT] | fuse_s;
   assign irqe_eff = s_r.irq_en & ~fuse_s;

   always_comb begin
      if (fuse_s) begin
         mode = wdtrf_pkg::wdtrf_rst_only;
      end else begin
         case ({wde_eff, irqe_eff})
            2'b01:   mode = wdtrf_pkg::wdtrf_irq_only;
            2'b10:   mode = wdtrf_pkg::wdtrf_rst_only;
            2'b11:   mode = wdtrf_pkg::wdtrf_irq_rst;
            default: mode = wdtrf_pkg::wdtrf_stopped;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Time-out limit
   // ---------------------------------------------------------------
   logic [3:0]       code_eff;
   logic [CNT_W-1:0] limit;

   // Reserved codes run at the longest period rather than stall
   // Limitation: a reserved code still reads back as written
   assign code_eff = (s_r.psel > `WDTRF_PSEL_MAX) ? `WDTRF_PSEL_MAX : s_r.psel;
   assign limit    = {CNT_W{1'b1}} >> (`WDTRF_PSEL_MAX - code_eff);

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic        hit_ctrl;
   logic        hit_cause;
   logic        setup_rd;
   logic        wr_acc;
   logic        wr_ctrl;
   logic        wr_cause;
   logic        tick;
   logic        timeout;
   logic        sys_rst_any;
   logic [7:0]  ctrl_rd;
   logic [7:0]  wd;

   assign hit_ctrl  = (paddr_i == ADDR_W'(`WDTRF_CTRL_OFS));
   assign hit_cause = (paddr_i == ADDR_W'(`WDTRF_CAUSE_OFS));
   assign setup_rd  = psel_i & ~penable_i & ~pwrite_i;
   assign wr_acc    = psel_i & penable_i & pwrite_i & pstrb_i[0];
   assign wr_ctrl   = wr_acc & hit_ctrl;
   assign wr_cause  = wr_acc & hit_cause;
   assign wd        = pwdata_i[7:0];

   // ---------------------------------------------------------------
   // Oscillator tick and time-out
   // ---------------------------------------------------------------
   // Oscillator rising edge, seen once per cycle of it
   // Edges closer than two system cycles would be merged
   assign tick    = osc_s & ~s_r.osc_prev;
   assign timeout = tick & (mode != wdtrf_pkg::wdtrf_stopped)
                    & (s_r.cnt == limit) & ~wdr_i;

   // Any system reset other than power-on resets the control bits
   assign sys_rst_any = s_r.rst_pulse | pin_s | bor_s | scan_s;

   assign ctrl_rd = {s_r.irq_flag, irqe_eff, s_r.psel[3], s_r.ce,
                     wde_eff, s_r.psel[2:0]};

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      s_nxt           = s_r;
      s_nxt.osc_prev  = osc_s;
      s_nxt.rst_pulse = 1'b0;

      // Counter: restart wins over a coincident tick
      if (wdr_i || mode == wdtrf_pkg::wdtrf_stopped) begin
         s_nxt.cnt = '0;
      end else if (tick) begin
         s_nxt.cnt = (s_r.cnt == limit) ? '0 : s_r.cnt + 1'b1;
      end

      // Change window runs down on the system clock
      // Writes on the four edges after the opening one may use it
      if (s_r.ce) begin
         if (s_r.ce_cnt == 3'h1) begin
            s_nxt.ce     = 1'b0;
            s_nxt.ce_cnt = 3'h0;
         end else begin
            s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
         end
      end

      // Control write: protected fields obey the window
      if (wr_ctrl) begin
         s_nxt.irq_en = wd[`WDTRF_IRQE_BIT];
         if (wd[`WDTRF_IRQF_BIT]) begin
            s_nxt.irq_flag = 1'b0;
         end
         if (wd[`WDTRF_WDE_BIT]) begin
            s_nxt.reset_enable = 1'b1;
         end else if (s_r.ce && !s_r.cause[`WDTRF_WATCHDOG_RESET_FLAG_BIT]) begin
            s_nxt.reset_enable = 1'b0;
         end
         if (s_r.ce) begin
            s_nxt.psel = {wd[`WDTRF_PSEL3_BIT], wd[2:0]};
         end
         // Opening needs both enables in one write; any other write closes it
         if (wd[`WDTRF_CE_BIT] && wd[`WDTRF_WDE_BIT]) begin
            s_nxt.ce     = 1'b1;
            s_nxt.ce_cnt = `WDTRF_CE_CYCLES;
         end else begin
            s_nxt.ce     = 1'b0;
            s_nxt.ce_cnt = 3'h0;
         end
      end

      // Cause flags: writing zero clears, ones keep
      if (wr_cause) begin
         s_nxt.cause = s_r.cause & wd[4:0];
      end

      // Vector execution; combined mode also drops the enable
      if (irq_ack_i) begin
         s_nxt.irq_flag = 1'b0;
         if (mode == wdtrf_pkg::wdtrf_irq_rst) begin
            s_nxt.irq_en = 1'b0;
         end
      end

      // Time-out action; flag set wins over a same-cycle clear
      if (timeout) begin
         case (mode)
            wdtrf_pkg::wdtrf_irq_only: begin
               s_nxt.irq_flag = 1'b1;
            end
            wdtrf_pkg::wdtrf_rst_only: begin
               s_nxt.rst_pulse = 1'b1;
            end
            wdtrf_pkg::wdtrf_irq_rst: begin
               if (s_r.irq_flag) begin
                  s_nxt.rst_pulse = 1'b1;
               end else begin
                  s_nxt.irq_flag = 1'b1;
               end
            end
            default: begin
               s_nxt.rst_pulse = 1'b0;
            end
         endcase
      end

      // Reset sources set their flags; set beats a software clear
      if (s_r.rst_pulse) begin
         s_nxt.cause[`WDTRF_WATCHDOG_RESET_FLAG_BIT] = 1'b1;
      end
      if (scan_s) begin
         s_nxt.cause[`WDTRF_SCAN_BIT] = 1'b1;
      end
      if (bor_s) begin
         s_nxt.cause[`WDTRF_BOR_BIT] = 1'b1;
      end
      if (pin_s) begin
         s_nxt.cause[`WDTRF_PIN_BIT] = 1'b1;
      end

      // System reset clears control state but never the cause flags
      // A long pin reset keeps the control word cleared while high
      if (sys_rst_any) begin
         s_nxt.cnt      = '0;
         s_nxt.irq_flag = 1'b0;
         s_nxt.irq_en   = 1'b0;
         s_nxt.psel     = 4'h0;
         s_nxt.ce       = 1'b0;
         s_nxt.ce_cnt   = 3'h0;
         s_nxt.reset_enable      = 1'b0;
      end

      // Fuse pins the enables whatever software wrote
      if (fuse_s) begin
         s_nxt.reset_enable    = 1'b1;
         s_nxt.irq_en = 1'b0;
      end

      // Read data captured in the setup phase
      if (setup_rd) begin
         if (hit_ctrl) begin
            s_nxt.rdata = {24'h000000, ctrl_rd};
         end else if (hit_cause) begin
            s_nxt.rdata = {27'h0000000, s_r.cause};
         end else begin
            s_nxt.rdata = 32'h00000000;
         end
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // Power-on leaves only the power-on flag set
   // Other cause flags clear here
   always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         s_r       <= '0;
         s_r.cause <= `WDTRF_CAUSE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Zero wait states; unmapped addresses raise an error
   // Request is a level; it drops once the core takes the vector
   assign pready_o    = 1'b1;
   assign pslverr_o   = psel_i & penable_i & ~(hit_ctrl | hit_cause);
   assign prdata_o    = s_r.rdata;
   assign irq_o       = s_r.irq_flag & irqe_eff & global_irq_en_i;
   assign sys_reset_o = s_r.rst_pulse;

endmodule : wdtrf_top

// File: dv/wdtrf_props.sv
`timescale 1ns/1ps
`include "wdtrf_cfg.svh"

module wdtrf_props #(
   parameter int ADDR_W = 12
) (
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic [ADDR_W-1:0] paddr_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       prdata_o,
   input  wire logic              pready_o,
   input  wire logic              pslverr_o,
   input  wire logic              global_irq_en_i,
   input  wire logic              irq_ack_i,
   input  wire logic              irq_o,
   input  wire logic              sys_reset_o
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Address decode of the two mapped words
   logic hit;
   assign hit = (paddr_i == `WDTRF_CTRL_OFS) || (paddr_i == `WDTRF_CAUSE_OFS);

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // Bus phases
   sequence s_acc;
      psel_i && penable_i;
   endsequence
   sequence s_rset;
      psel_i && !penable_i && !pwrite_i && !hit;
   endsequence

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_err;
      s_acc |-> (pslverr_o == !hit);
   endproperty
   property p_urd;
      s_rset |=> (prdata_o == 32'h0);
   endproperty
   property p_hi;
      prdata_o[31:8] == 24'h0;
   endproperty
   property p_rdy;
      pready_o;
   endproperty
   property p_gate;
      irq_o |-> global_irq_en_i;
   endproperty
   property p_pulse;
      $rose(sys_reset_o) |=> !sys_reset_o;
   endproperty
   property p_ack;
      irq_ack_i |=> !irq_o;
   endproperty
   property p_rstq;
      sys_reset_o |=> !irq_o [*2];
   endproperty
   property p_post;
      $rose(rst_n_i) |-> !irq_o && !sys_reset_o;
   endproperty

   a_err:   assert property (p_err)   else $error("slave error does not match decode");
   a_urd:   assert property (p_urd)   else $error("unmapped read data not zero");
   a_hi:    assert property (p_hi)    else $error("upper read data bits not zero");
   a_rdy:   assert property (p_rdy)   else $error("ready dropped");
   a_gate:  assert property (p_gate)  else $error("irq without global enable");
   a_pulse: assert property (p_pulse) else $error("reset pulse too long");
   a_ack:   assert property (p_ack)   else $error("irq stays after vector");
   a_rstq:  assert property (p_rstq)  else $error("irq after system reset");
   a_post:  assert property (p_post)  else $error("outputs active after reset");
endmodule : wdtrf_props

bind wdtrf_top wdtrf_props #(.ADDR_W(ADDR_W)) wdtrf_props_inst (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .global_irq_en_i(global_irq_en_i), .irq_ack_i(irq_ack_i),
   .irq_o(irq_o), .sys_reset_o(sys_reset_o));

// File: dv/wdtrf_core_model.sv
`timescale 1ns/1ps

module wdtrf_core_model #(
   parameter int OSC_HALF_NS = 97
) (
   input  wire logic clk_sys_i,
   input  wire logic osc_run_i,
   input  wire logic auto_ack_i,
   input  wire logic irq_i,
   output logic      wdt_osc_o,
   output logic      irq_ack_o
);
   // ----------------------------------------
   // Oscillator and vector fetch
   // ----------------------------------------
   // Own phase, parked low while stopped so no stray ticks
   initial wdt_osc_o = 1'b0;
   always #(OSC_HALF_NS) wdt_osc_o = osc_run_i ? ~wdt_osc_o : 1'b0;
   // Vector taken once per request; never re-arms from the handler
   initial irq_ack_o = 1'b0;
   always @(posedge clk_sys_i) irq_ack_o <= auto_ack_i && irq_i && !irq_ack_o;
endmodule : wdtrf_core_model

// File: dv/tb_watchdog_timer_reset_flags.sv
`timescale 1ns/1ps
`include "wdtrf_cfg.svh"

module tb_watchdog_timer_reset_flags;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   localparam int    BL = 2;
   localparam [11:0] CT = `WDTRF_CTRL_OFS;
   localparam [11:0] CS = `WDTRF_CAUSE_OFS;
   logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
   logic        pwrite_i = 1'b0, gie = 1'b0, wdr_i = 1'b0, fuse_i = 1'b0;
   logic        pin_i = 1'b0, bor_i = 1'b0, scan_i = 1'b0, osc_run = 1'b0, auto_ack = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o;
   logic        pready_o, pslverr_o, irq_o, sys_reset_o, irq_ack_i, wdt_osc_i;
   logic [32:0] q[$];
   logic [7:0]  cm[3] = '{8'h02, 8'h04, 8'h10};
   logic [7:0]  ex;
   int          err_total = 0, checks_done = 0, n_osc = 0;

   always #12.5 clk_sys_i = ~clk_sys_i;
   always @(posedge wdt_osc_i) n_osc++;

   wdtrf_top #(.BASE_LOG2(BL)) wdtrf_top_inst (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .global_irq_en_i(gie), .irq_ack_i(irq_ack_i), .wdr_i(wdr_i), .irq_o(irq_o),
      .sys_reset_o(sys_reset_o), .wdt_osc_i(wdt_osc_i), .always_on_fuse_i(fuse_i),
      .pin_reset_i(pin_i), .brownout_reset_i(bor_i), .scan_reset_i(scan_i));
   wdtrf_core_model wdtrf_core_model_inst (
      .clk_sys_i(clk_sys_i), .osc_run_i(osc_run), .auto_ack_i(auto_ack), .irq_i(irq_o),
      .wdt_osc_o(wdt_osc_i), .irq_ack_o(irq_ack_i));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Read results are matched in order of issue
   always @(posedge clk_sys_i) begin
      if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) chk({pslverr_o, prdata_o}, q.pop_front());
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic [32:0] e);
      @(posedge clk_sys_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= {24'($urandom), d};
      if (!w) q.push_back(e);
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1) @(posedge clk_sys_i);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, '0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic er = 1'b0);
      apb(1'b0, a, 8'h00, {er, 24'h0, d});
   endtask : rd

   task automatic kick;
      @(posedge clk_sys_i);
      wdr_i <= 1'b1;
      @(posedge clk_sys_i);
      wdr_i <= 1'b0;
   endtask : kick

   // Bounded wait for irq (0) or system reset pulse (1)
   task automatic waitfor(input logic rs);
      int k;
      k = 0;
      while (((rs ? sys_reset_o : irq_o) !== 1'b1) && k < 3000) begin
         @(posedge clk_sys_i);
         k++;
      end
      chk({32'h0, (rs ? sys_reset_o : irq_o)}, 33'h1);
   endtask : waitfor

   function automatic logic [7:0] pb(input int c);
      return {2'b00, c[3], 2'b00, c[2:0]};
   endfunction : pb

   task automatic wrap_up;
      $display("checks=%0d mismatches=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   // Watchdog against hangs, far beyond the expected thirteen hundred or so cycles
   initial begin
      repeat (40000) @(posedge clk_sys_i);
      err_total++;
      wrap_up();
   end

   initial begin
      void'($urandom(83938));
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rd(CS, 8'h01);
      rd(CT, 8'h00);
      rd(12'h068, 8'h00, 1'b1);
      $display("test reset_values done");
      // Oscillator parked: protection checks with no time-outs
      wr(CT, 8'h08);
      wr(CT, 8'h00);
      wr(CT, 8'h09);
      rd(CT, 8'h08);
      wr(CT, 8'h18);
      rd(CT, 8'h18);
      repeat (4) @(posedge clk_sys_i);
      wr(CT, 8'h00);
      rd(CT, 8'h08);
      $display("test protection done");
      gie     <= 1'b1;
      osc_run <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         kick();
         wr(CT, 8'h18);
         wr(CT, 8'h40 | pb(c));
         @(posedge wdt_osc_i);
         repeat (3) @(posedge clk_sys_i);
         kick();
         n_osc = 0;
         waitfor(1'b0);
         chk({1'b0, 32'(n_osc)}, {1'b0, 32'(1 << (BL + c))});
         rd(CT, 8'hC0 | pb(c));
         gie <= 1'b0;
         repeat (2) @(posedge clk_sys_i);
         chk({32'h0, irq_o}, 33'h0);
         gie <= 1'b1;
         wr(CT, 8'hC0 | pb(c));
         rd(CT, 8'h40 | pb(c));
      end
      $display("test periods done");
      for (int a = 1; a >= 0; a--) begin
         auto_ack <= 1'(a);
         wr(CT, 8'h48);
         kick();
         osc_run <= 1'b1;
         waitfor(1'b0);
         if (a == 1) rd(CT, 8'h0B);
         waitfor(1'b1);
         osc_run <= 1'b0;
         rd(CS, 8'h09);
         rd(CT, 8'h08);
      end
      wr(CT, 8'h18);
      wr(CT, 8'h00);
      rd(CT, 8'h08);
      wr(CS, 8'h00);
      rd(CS, 8'h00);
      wr(CT, 8'h18);
      wr(CT, 8'h00);
      rd(CT, 8'h00);
      $display("test combined_mode done");
      ex = 8'h00;
      for (int i = 0; i < 3; i++) begin
         {scan_i, bor_i, pin_i} <= 3'(1 << i);
         repeat (3) @(posedge clk_sys_i);
         {scan_i, bor_i, pin_i} <= 3'b000;
         repeat (4) @(posedge clk_sys_i);
         ex = ex | cm[i];
         rd(CS, ex);
      end
      fuse_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rd(CT, 8'h08);
      wr(CT, 8'h40);
      rd(CT, 8'h08);
      wr(CT, 8'h18);
      wr(CT, 8'h2A);
      rd(CT, 8'h2A);
      $display("test reset_sources done");
      // Second power-on mid-run: only the power-on flag survives
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rd(CS, 8'h01);
      rd(CT, 8'h08);
      // Let the last read be compared before the verdict
      repeat (2) @(posedge clk_sys_i);
      chk(33'(q.size()), 33'h0);
      $display("test power_on done");
      wrap_up();
   end
endmodule : tb_watchdog_timer_reset_flags
